// ===== hw/scpr_defs.svh
`ifndef SCPR_DEFS_SVH
`define SCPR_DEFS_SVH

// Register byte addresses
`define SCPR_SERIAL_OFFSET    8'h00
`define SCPR_CAN_OFFSET       8'h04

// Serial routing register, implemented width and reset value
`define SCPR_SERIAL_WIDTH     14
`define SCPR_SERIAL_RESET     14'h0000

// Serial routing field positions (low bit of each 2-bit field)
`define SCPR_CH5_SOUT_LSB     12
`define SCPR_CH5_DIN_LSB      10
`define SCPR_CH4_SCLK_LSB     8
`define SCPR_CH4_SOUT_LSB     6
`define SCPR_CH4_DIN_LSB      4
`define SCPR_CH4_CTS_LSB      2
`define SCPR_CH4_RTS_LSB      0

// CAN, trigger and counter register reset value
`define SCPR_CAN_RESET        32'h0000_0000

// CAN, trigger and counter field positions
`define SCPR_CAN1_TX_LSB      30
`define SCPR_CAN1_RX_LSB      28
`define SCPR_CAN0_TX_LSB      26
`define SCPR_CAN0_RX_LSB      24
`define SCPR_TRIG0_LSB        12
`define SCPR_TRIG_WIDTH       4
`define SCPR_COUNTER_LSB      0

// Highest legal trigger source code
`define SCPR_TRIG_MAX_CODE    4'h9

`endif

// ===== hw/scpr_pkg.sv
package scpr_pkg;

    typedef logic [1:0] scpr_route_type;
    typedef logic [3:0] scpr_trig_type;

    // Pin instance picked by a 2-bit route code; 00 and 01 share instance 0
    function automatic logic [1:0] scpr_route_inst(input scpr_route_type sel);
        if (sel == 2'h3) begin
            return 2'h2;
        end else if (sel == 2'h2) begin
            return 2'h1;
        end
        return 2'h0;
    endfunction

    // Trigger source index; prohibited codes fall back to source 0
    function automatic logic [3:0] scpr_trig_index(input scpr_trig_type code);
        if (code <= 4'h1 || code > 4'h9) begin
            return 4'h0;
        end
        return code - 4'h1;
    endfunction

endpackage

// ===== hw/scpr_in_route.sv
`timescale 1ns/100ps
module scpr_in_route
    import scpr_pkg::*;
(
    // Route code
    input  wire scpr_route_type routeSel,
    // Pin instances
    input  wire logic [2:0]     pinIn,
    // Peripheral input
    output logic                periphIn
);

    logic [1:0] inst;

    assign inst     = scpr_route_inst(routeSel);
    assign periphIn = pinIn[inst];

endmodule // scpr_in_route

// ===== hw/scpr_out_route.sv
`timescale 1ns/100ps
module scpr_out_route
    import scpr_pkg::*;
(
    // Route code
    input  wire scpr_route_type routeSel,
    // Peripheral side
    input  wire logic           periphOut,
    output logic                periphIn,
    // Pin side
    input  wire logic [2:0]     pinIn,
    output logic [2:0]          pinOut,
    output logic [2:0]          pinOeN
);

    logic [1:0] inst;
    logic       drive;

    assign inst     = scpr_route_inst(routeSel);
    assign drive    = (routeSel != 2'h0);
    assign periphIn = pinIn[inst];

    // Unselected instances stay released for other pin functions
    generate
        for (genvar i = 0; i < 3; i++) begin : g_pin
            assign pinOut[i] = (drive && inst == 2'(i)) ? periphOut : 1'b0;
            assign pinOeN[i] = !(drive && inst == 2'(i));
        end
    endgenerate

endmodule // scpr_out_route

// ===== hw/scpr_top.sv
// Behaviour
// - Channel 5 output code 00: input from instance 0, no pin driven.
// - Channel 5 output codes 01/10/11: instance 0/1/2 both directions.
// - Channel 5 input: 00,01 instance 0; 10 instance 1; 11 instance 2.
// - Channel 4 clock code 00: clock in from instance 0, no output.
// - Channel 4 clock codes 01/10/11: instance 0/1/2 both directions.
// - Channel 4 output: 00 input-only instance 0; else instances 0/1/2.
// - Channel 4 input: 00,01 instance 0; 10 instance 1; 11 instance 2.
// - Channel 4 clear-to-send: 00,01 instance 0; 10 one; 11 two.
// - Channel 4 request-to-send: 00 no output; else drives instance 0/1/2.
// - Reads return the last written field values without side effects.
// - Serial routing survives deep standby reset; other resets clear it.
// - CAN/trigger/counter register holds all fields read/write, reset zero.
// - CAN 1 transmit: 00 no output; 01/10/11 drive instance 0/1/2.
// - CAN 1 receive: 00,01 instance 0; 10 instance 1; 11 instance 2.
`timescale 1ns/100ps
`include "scpr_defs.svh"
module scpr_top
    import scpr_pkg::*;
(
    // Clock and resets
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        deepStandbyReset,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [31:0]      regRdata,
    // Channel 5 serial data out line
    input  wire logic        ch5SoutPeriph,
    output logic             ch5SoutFeedback,
    input  wire logic [2:0]  ch5SoutPinIn,
    output logic [2:0]       ch5SoutPinOut,
    output logic [2:0]       ch5SoutPinOeN,
    // Channel 5 serial data in line
    input  wire logic [2:0]  ch5DinPins,
    output logic             ch5DinPeriph,
    // Channel 4 serial clock line
    input  wire logic        ch4SclkPeriph,
    output logic             ch4SclkFeedback,
    input  wire logic [2:0]  ch4SclkPinIn,
    output logic [2:0]       ch4SclkPinOut,
    output logic [2:0]       ch4SclkPinOeN,
    // Channel 4 serial data out line
    input  wire logic        ch4SoutPeriph,
    output logic             ch4SoutFeedback,
    input  wire logic [2:0]  ch4SoutPinIn,
    output logic [2:0]       ch4SoutPinOut,
    output logic [2:0]       ch4SoutPinOeN,
    // Channel 4 serial data in and clear-to-send lines
    input  wire logic [2:0]  ch4DinPins,
    output logic             ch4DinPeriph,
    input  wire logic [2:0]  ch4CtsPins,
    output logic             ch4CtsPeriph,
    // Channel 4 request-to-send line
    input  wire logic        ch4RtsPeriph,
    output logic [2:0]       ch4RtsPinOut,
    output logic [2:0]       ch4RtsPinOeN,
    // CAN 1 lines
    input  wire logic        can1TxPeriph,
    output logic [2:0]       can1TxPinOut,
    output logic [2:0]       can1TxPinOeN,
    input  wire logic [2:0]  can1RxPins,
    output logic             can1RxPeriph,
    // CAN 0 lines
    input  wire logic        can0TxPeriph,
    output logic [2:0]       can0TxPinOut,
    output logic [2:0]       can0TxPinOeN,
    input  wire logic [2:0]  can0RxPins,
    output logic             can0RxPeriph,
    // Converter start triggers
    input  wire logic [8:0]  trigSources,
    output logic [2:0]       convTrigger,
    // Quadrature counter inputs, three pins per field
    input  wire logic [17:0] counterPins,
    output logic [5:0]       counterInputs
);

    logic [`SCPR_SERIAL_WIDTH-1:0] serialRoute;
    logic [31:0]                   canRoute;
    logic                          serialSel;
    logic                          canSel;

    assign serialSel = (regAddr == `SCPR_SERIAL_OFFSET);
    assign canSel    = (regAddr == `SCPR_CAN_OFFSET);

    // Deep standby reset leaves serial routing intact so its pins keep their function; CAN routing is cleared
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            if (!deepStandbyReset) begin
                serialRoute <= `SCPR_SERIAL_RESET;
            end
        end else if (regWrite && serialSel) begin
            serialRoute <= regWdata[`SCPR_SERIAL_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            canRoute <= `SCPR_CAN_RESET;
        end else if (regWrite && canSel) begin
            canRoute <= regWdata;
        end
    end

    // Read data stand for one cycle only; unmapped and idle read zero
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead && serialSel) begin
            regRdata <= {18'h00000, serialRoute};
        end else if (regRead && canSel) begin
            regRdata <= canRoute;
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    // Two-way serial lines
    scpr_out_route u_ch5_sout (
        .routeSel  (serialRoute[`SCPR_CH5_SOUT_LSB +: 2]),
        .periphOut (ch5SoutPeriph),
        .periphIn  (ch5SoutFeedback),
        .pinIn     (ch5SoutPinIn),
        .pinOut    (ch5SoutPinOut),
        .pinOeN    (ch5SoutPinOeN)
    );

    scpr_out_route u_ch4_sclk (
        .routeSel  (serialRoute[`SCPR_CH4_SCLK_LSB +: 2]),
        .periphOut (ch4SclkPeriph),
        .periphIn  (ch4SclkFeedback),
        .pinIn     (ch4SclkPinIn),
        .pinOut    (ch4SclkPinOut),
        .pinOeN    (ch4SclkPinOeN)
    );

    scpr_out_route u_ch4_sout (
        .routeSel  (serialRoute[`SCPR_CH4_SOUT_LSB +: 2]),
        .periphOut (ch4SoutPeriph),
        .periphIn  (ch4SoutFeedback),
        .pinIn     (ch4SoutPinIn),
        .pinOut    (ch4SoutPinOut),
        .pinOeN    (ch4SoutPinOeN)
    );

    // Output-only lines; their input path is not used
    scpr_out_route u_ch4_rts (
        .routeSel  (serialRoute[`SCPR_CH4_RTS_LSB +: 2]),
        .periphOut (ch4RtsPeriph),
        .periphIn  (),
        .pinIn     (3'h0),
        .pinOut    (ch4RtsPinOut),
        .pinOeN    (ch4RtsPinOeN)
    );

    scpr_out_route u_can1_tx (
        .routeSel  (canRoute[`SCPR_CAN1_TX_LSB +: 2]),
        .periphOut (can1TxPeriph),
        .periphIn  (),
        .pinIn     (3'h0),
        .pinOut    (can1TxPinOut),
        .pinOeN    (can1TxPinOeN)
    );

    scpr_out_route u_can0_tx (
        .routeSel  (canRoute[`SCPR_CAN0_TX_LSB +: 2]),
        .periphOut (can0TxPeriph),
        .periphIn  (),
        .pinIn     (3'h0),
        .pinOut    (can0TxPinOut),
        .pinOeN    (can0TxPinOeN)
    );

    // Input-only lines
    scpr_in_route u_ch5_din (
        .routeSel (serialRoute[`SCPR_CH5_DIN_LSB +: 2]),
        .pinIn    (ch5DinPins),
        .periphIn (ch5DinPeriph)
    );

    scpr_in_route u_ch4_din (
        .routeSel (serialRoute[`SCPR_CH4_DIN_LSB +: 2]),
        .pinIn    (ch4DinPins),
        .periphIn (ch4DinPeriph)
    );

    scpr_in_route u_ch4_cts (
        .routeSel (serialRoute[`SCPR_CH4_CTS_LSB +: 2]),
        .pinIn    (ch4CtsPins),
        .periphIn (ch4CtsPeriph)
    );

    scpr_in_route u_can1_rx (
        .routeSel (canRoute[`SCPR_CAN1_RX_LSB +: 2]),
        .pinIn    (can1RxPins),
        .periphIn (can1RxPeriph)
    );

    scpr_in_route u_can0_rx (
        .routeSel (canRoute[`SCPR_CAN0_RX_LSB +: 2]),
        .pinIn    (can0RxPins),
        .periphIn (can0RxPeriph)
    );

    generate
        for (genvar k = 0; k < 6; k++) begin : g_counter
            scpr_in_route u_sel (
                .routeSel (canRoute[`SCPR_COUNTER_LSB + 2*k +: 2]),
                .pinIn    (counterPins[3*k +: 3]),
                .periphIn (counterInputs[k])
            );
        end
        // Prohibited codes are not trapped, only steered to source 0
        for (genvar t = 0; t < 3; t++) begin : g_trig
            assign convTrigger[t] = trigSources[scpr_trig_index(
                canRoute[`SCPR_TRIG0_LSB + 4*t +: 4])];
        end
    endgenerate

    // Checks
    sequence serialWriteSeq;
        regWrite && serialSel;
    endsequence

    sequence serialReadSeq;
        regRead && serialSel && !regWrite;
    endsequence

    ser_write_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialWriteSeq |=> serialRoute == $past(regWdata[13:0]))
        else $error("serial route write not stored");

    ser_readback_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialWriteSeq ##1 serialReadSeq |=>
            regRdata == {18'h00000, $past(regWdata[13:0], 2)})
        else $error("serial route read-back differs from write");

    can_readback_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        regRead && canSel |=> regRdata == $past(canRoute))
        else $error("CAN route read-back wrong");

    ds_retain_a: assert property (@(posedge sys_clk)
        !nrst && deepStandbyReset |=> serialRoute == $past(serialRoute))
        else $error("serial routing lost on deep standby reset");

    cold_reset_a: assert property (@(posedge sys_clk)
        !nrst && !deepStandbyReset |=> serialRoute == 14'h0000
            && canRoute == 32'h0000_0000)
        else $error("routing not cleared by reset");

    ch5_idle_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[13:12] == 2'h0 |->
            ch5SoutPinOeN == 3'h7 && ch5SoutFeedback == ch5SoutPinIn[0])
        else $error("channel 5 output idle routing wrong");

    ch5_drive_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[13:12] == 2'h3 |->
            ch5SoutPinOeN == 3'h3 && ch5SoutPinOut[2] == ch5SoutPeriph
            && ch5SoutFeedback == ch5SoutPinIn[2])
        else $error("channel 5 output instance 2 routing wrong");

    ch5_in_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[11:10] == 2'h1 |-> ch5DinPeriph == ch5DinPins[0])
        else $error("channel 5 input code 01 not instance 0");

    sclk_route_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[9:8] == 2'h2 |->
            ch4SclkPinOeN == 3'h5 && ch4SclkFeedback == ch4SclkPinIn[1])
        else $error("channel 4 clock instance 1 routing wrong");

    sout4_route_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[7:6] == 2'h1 |->
            ch4SoutPinOeN == 3'h6 && ch4SoutPinOut[0] == ch4SoutPeriph)
        else $error("channel 4 output instance 0 routing wrong");

    cts_route_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[3:2] == 2'h2 |-> ch4CtsPeriph == ch4CtsPins[1])
        else $error("clear-to-send instance 1 routing wrong");

    rts_release_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[1:0] == 2'h0 |->
            ch4RtsPinOeN == 3'h7 && ch4RtsPinOut == 3'h0)
        else $error("request-to-send driven while disabled");

    can_tx_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        regWrite && canSel && regWdata[31:30] == 2'h2 |=>
            can1TxPinOeN == 3'h5 && can1TxPinOut[1] == can1TxPeriph)
        else $error("CAN 1 transmit not on instance 1 after write");

    can_rx_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        canRoute[29:28] == 2'h3 |-> can1RxPeriph == can1RxPins[2])
        else $error("CAN 1 receive instance 2 routing wrong");

    sclk_idle_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[9:8] == 2'h0 |->
            ch4SclkPinOeN == 3'h7 && ch4SclkFeedback == ch4SclkPinIn[0])
        else $error("channel 4 clock idle routing wrong");

    din4_route_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[5:4] == 2'h3 |-> ch4DinPeriph == ch4DinPins[2])
        else $error("channel 4 input instance 2 routing wrong");

    rts_drive_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        serialRoute[1:0] == 2'h1 |->
            ch4RtsPinOeN == 3'h6 && ch4RtsPinOut[0] == ch4RtsPeriph)
        else $error("request-to-send not on instance 0");

    trig_route_a: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        canRoute[15:12] == 4'h9 |-> convTrigger[0] == trigSources[8])
        else $error("converter 0 trigger code 1001 not on source 8");

endmodule // scpr_top

// ===== tb/scpr_periph_model.sv
`timescale 1ns/100ps
module scpr_periph_model
    import scpr_pkg::*;
(
    // Clock and reset
    input  wire logic  sys_clk,
    input  wire logic  nrst,
    // Peripheral output levels, one per output line
    output logic [5:0] periphOut
);
    // Toggle each cycle so a stuck pin output cannot pass as a match
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            periphOut <= 6'h15;
        end else begin
            periphOut <= ~periphOut;
        end
    end
endmodule // scpr_periph_model

// ===== tb/scpr_top_bench.sv
`timescale 1ns/100ps
module scpr_top_bench
    import scpr_pkg::*;
;
    logic        sys_clk;
    logic        nrst;
    logic        dsr;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWrite;
    logic        regRead;
    logic [2:0]  pins;
    logic [8:0]  trigSrc;
    logic [31:0] q;
    int          mismatches;
    int          num_checks;
    wire  [31:0] regRdata;
    wire  [5:0]  pOut;
    wire  [2:0]  fb;
    wire  [4:0]  inw;
    wire  [5:0]  cnt;
    wire  [2:0]  trg;
    wire  [2:0]  oeN [6];
    wire  [2:0]  pinO [6];

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    scpr_periph_model PEER (.sys_clk(sys_clk), .nrst(nrst), .periphOut(pOut));

    scpr_top DUT (
        .sys_clk(sys_clk), .nrst(nrst), .deepStandbyReset(dsr),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata),
        .ch5SoutPeriph(pOut[0]), .ch5SoutFeedback(fb[0]),
        .ch5SoutPinIn(pins), .ch5SoutPinOut(pinO[0]),
        .ch5SoutPinOeN(oeN[0]), .ch5DinPins(pins), .ch5DinPeriph(inw[0]),
        .ch4SclkPeriph(pOut[1]), .ch4SclkFeedback(fb[1]),
        .ch4SclkPinIn(pins), .ch4SclkPinOut(pinO[1]),
        .ch4SclkPinOeN(oeN[1]),
        .ch4SoutPeriph(pOut[2]), .ch4SoutFeedback(fb[2]),
        .ch4SoutPinIn(pins), .ch4SoutPinOut(pinO[2]),
        .ch4SoutPinOeN(oeN[2]), .ch4DinPins(pins), .ch4DinPeriph(inw[1]),
        .ch4CtsPins(pins), .ch4CtsPeriph(inw[2]),
        .ch4RtsPeriph(pOut[3]), .ch4RtsPinOut(pinO[3]),
        .ch4RtsPinOeN(oeN[3]),
        .can1TxPeriph(pOut[4]), .can1TxPinOut(pinO[4]),
        .can1TxPinOeN(oeN[4]), .can1RxPins(pins), .can1RxPeriph(inw[3]),
        .can0TxPeriph(pOut[5]), .can0TxPinOut(pinO[5]),
        .can0TxPinOeN(oeN[5]), .can0RxPins(pins), .can0RxPeriph(inw[4]),
        .trigSources(trigSrc), .convTrigger(trg),
        .counterPins({6{pins}}), .counterInputs(cnt)
    );

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // Write and read with no idle cycle between the two strobes
    task automatic wrrd(input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regRead  <= 1'b1;
        @(posedge sys_clk);
        regRead  <= 1'b0;
        #1;
        r = regRdata;
    endtask

    task automatic rst(input logic keep);
        @(posedge sys_clk);
        nrst <= 1'b0;
        dsr  <= keep;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        dsr  <= 1'b0;
    endtask

    // All fields of one kind carry the same code, pins one-hot at its pick
    task automatic route_case(input logic [1:0] c);
        logic [1:0]  inst;
        logic [2:0]  oe;
        logic [31:0] canVal;
        inst   = (c == 2'h3) ? 2'h2 : ((c == 2'h2) ? 2'h1 : 2'h0);
        oe     = (c == 2'h0) ? 3'h7 : ~(3'h1 << (c - 2'h1));
        canVal = {{4{c}}, 12'h000, {6{c}}};
        @(posedge sys_clk);
        pins  <= 3'h1 << inst;
        wr(8'h00, 32'hffff_c000 | {18'h0, {7{c}}});
        wr(8'h04, canVal);
        repeat (2) begin
            for (int i = 0; i < 6; i++) begin
                check("pin enable", oeN[i], oe);
                check("pin out", pinO[i], {3{pOut[i]}} & ~oe);
            end
            check("feedback", fb, 3'h7);
            check("inputs", inw, 5'h1f);
            check("counter in", cnt, 6'h3f);
            @(posedge sys_clk);
            #1;
        end
        rd(8'h00, q);
        check("serial read", q, {18'h0, {7{c}}});
        rd(8'h04, q);
        check("can read", q, canVal);
    endtask

    initial begin
        nrst = 1'b0;
        dsr = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        pins = 3'h0;
        trigSrc = 9'h0;
        mismatches = 0;
        num_checks = 0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(8'h00, q);
        check("serial reset", q, 32'h0);
        rd(8'h04, q);
        check("can reset", q, 32'h0);
        check("released", oeN[0] & oeN[3] & oeN[4], 3'h7);
        for (int c = 3; c >= 0; c--) route_case(2'(c));
        // Read right behind the write must already see the new value
        wrrd(8'h00, 32'h0000_3000, q);
        check("write then read", q, 32'h0000_3000);
        check("walk enable", oeN[0], 3'h3);
        // Codes above 1001 never written, the software side keeps that
        for (int k = 0; k < 10; k++) begin
            @(posedge sys_clk);
            trigSrc <= 9'h1 << ((k <= 1) ? 0 : k - 1);
            wr(8'h04, {8'h00, 4'(k), 4'(k), 4'(k), 12'h000});
            check("trigger", trg, 3'h7);
        end
        wr(8'h00, 32'h0000_2a5b);
        wr(8'h04, 32'h1234_5678);
        rd(8'h04, q);
        check("can stored", q, 32'h1234_5678);
        @(posedge sys_clk);
        #1;
        check("read idle", regRdata, 32'h0);
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08, q);
        check("unmapped", q, 32'h0);
        rd(8'h04, q);
        check("can kept", q, 32'h1234_5678);
        rst(1'b1);
        rd(8'h00, q);
        check("standby keep", q, 32'h0000_2a5b);
        rd(8'h04, q);
        check("can cleared", q, 32'h0);
        rst(1'b0);
        rd(8'h00, q);
        check("serial cleared", q, 32'h0);
        conclude();
    end

    // Hang guard
    initial begin
        repeat (50000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end
endmodule // scpr_top_bench
